// File: design/i2cgx_pkg.sv
// shared constants and types for the i2c port expander core
`default_nettype none
package i2cgx_pkg;
   localparam int unsigned PORT_W     = 8;
   localparam logic [3:0]  ADDR_FIXED = 4'h3;
   localparam logic [1:0]  PTR_INPUT  = 2'h0;
   localparam logic [1:0]  PTR_LATCH  = 2'h1;
   localparam logic [1:0]  PTR_INVERT = 2'h2;
   localparam logic [1:0]  PTR_DIR    = 2'h3;
   localparam logic [7:0]  RST_PTR    = 8'h00;
   localparam logic [7:0]  RST_LATCH  = 8'h00;
   localparam logic [7:0]  RST_INVERT = 8'hf0;
   localparam logic [7:0]  RST_DIR    = 8'hff;
   localparam logic [7:0]  RST_INPORT = 8'h00;
   localparam logic [2:0]  BIT_LAST   = 3'h7;
   localparam logic [1:0]  PRIME_DONE = 2'h3;

   typedef enum logic [3:0] {
      S_IDLE, S_ADDR, S_AACK, S_CMD, S_CACK, S_WDATA, S_WACK, S_RDATA, S_MACK, S_SKIP
   } i2cgx_state_t;

   typedef struct packed {
      logic [7:0] ptr;
      logic [7:0] latch;
      logic [7:0] invert;
      logic [7:0] dir;
      logic [7:0] inport;
   } i2cgx_regs_t;

   typedef struct packed {
      logic [7:0] level;
      logic [7:0] oe_n;
   } i2cgx_drv_t;

   typedef struct packed {
      i2cgx_state_t state;
      i2cgx_regs_t  regs;
      logic [1:0]   scl_s;
      logic [1:0]   sda_s;
      logic         scl_p;
      logic         sda_p;
      logic [7:0]   pin_s0;
      logic [7:0]   pin_s1;
      logic [2:0]   adr_s0;
      logic [2:0]   adr_s1;
      logic [7:0]   shreg;
      logic [2:0]   cnt;
      logic         full;
      logic         rw;
      logic         drv;
      logic         addressed;
      logic         nacked;
      logic         irq;
      logic [1:0]   prime;
   } i2cgx_st_t;
endpackage
`default_nettype wire

// File: design/i2cgx_core.sv
// i2c slave port expander: four registers, eight port pins, open-drain interrupt
`default_nettype none
module i2cgx_core
   import i2cgx_pkg::*;
(
   // clock, reset, enable
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       ce_i,
   // i2c bus, open drain
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_n_o,
   // address select straps
   input  wire logic [2:0] addr_select_pins_i,
   // port pins
   input  wire logic [7:0] port_pins_i,
   output var  i2cgx_drv_t port_drv_o,
   // interrupt, open drain
   output logic            irq_n_o,
   output logic            irq_oe_n_o
);

   localparam i2cgx_regs_t REGS_RST = '{
      ptr:    RST_PTR,
      latch:  RST_LATCH,
      invert: RST_INVERT,
      dir:    RST_DIR,
      inport: RST_INPORT
   };

   localparam i2cgx_st_t ST_RST = '{
      state:     S_IDLE,
      regs:      REGS_RST,
      scl_s:     2'h3,
      sda_s:     2'h3,
      scl_p:     1'b1,
      sda_p:     1'b1,
      pin_s0:    8'h00,
      pin_s1:    8'h00,
      adr_s0:    3'h0,
      adr_s1:    3'h0,
      shreg:     8'h00,
      cnt:       3'h0,
      full:      1'b0,
      rw:        1'b0,
      drv:       1'b0,
      addressed: 1'b0,
      nacked:    1'b0,
      irq:       1'b0,
      prime:     2'h0
   };

   logic [1:0] rst_sy_q;
   logic       rst_n;
   i2cgx_st_t  q;
   i2cgx_st_t  d;
   logic       scl;
   logic       sda;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_c;
   logic       stop_c;
   logic [6:0] dev_addr;
   logic [7:0] rd_byte;
   logic [7:0] mismatch;

   // reset released through two flops, asserted at once
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sy_q <= 2'h0;
      end else begin
         rst_sy_q <= {rst_sy_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sy_q[1];

   assign scl      = q.scl_s[1];
   assign sda      = q.sda_s[1];
   assign scl_rise = scl && !q.scl_p;
   assign scl_fall = !scl && q.scl_p;
   // sda moving while scl is high marks start or stop
   assign start_c  = scl && q.scl_p && q.sda_p && !sda;
   assign stop_c   = scl && q.scl_p && !q.sda_p && sda;
   assign dev_addr = {ADDR_FIXED, q.adr_s1};
   // only input pins can differ from the stored snapshot; quiet while the
   // synchronisers still hold reset zeros, else a false edge follows reset
   assign mismatch = (q.prime == PRIME_DONE) ? ((q.pin_s1 ^ q.regs.inport) & q.regs.dir)
                                             : 8'h00;

   always_comb begin
      case (q.regs.ptr[1:0])
         PTR_INPUT:  rd_byte = q.regs.inport ^ (q.regs.invert & q.regs.dir);
         PTR_LATCH:  rd_byte = q.regs.latch;
         PTR_INVERT: rd_byte = q.regs.invert;
         PTR_DIR:    rd_byte = q.regs.dir;
         default:    rd_byte = 8'h00;
      endcase
   end

   always_comb begin
      d        = q;
      d.scl_s  = {q.scl_s[0], scl_i};
      d.sda_s  = {q.sda_s[0], sda_i};
      d.pin_s0 = port_pins_i;
      d.pin_s1 = q.pin_s0;
      d.adr_s0 = addr_select_pins_i;
      d.adr_s1 = q.adr_s0;
      d.scl_p  = scl;
      d.sda_p  = sda;
      // level compare: a pin returning to its old level drops the request
      d.irq    = |mismatch;

      // wait for the pin synchronisers to fill before taking a snapshot
      if (q.prime != PRIME_DONE) begin
         d.prime       = q.prime + 2'h1;
         d.regs.inport = q.pin_s1;
      end

      if (stop_c) begin
         // partial bytes are dropped, committed registers stay
         d.state = S_IDLE;
         d.drv   = 1'b0;
         d.full  = 1'b0;
         if (q.addressed) begin
            d.regs.inport = q.pin_s1;
         end
         d.addressed = 1'b0;
      end else if (start_c) begin
         d.state     = S_ADDR;
         d.cnt       = 3'h0;
         d.full      = 1'b0;
         d.drv       = 1'b0;
         d.addressed = 1'b0;
      end else begin
         case (q.state)
            S_ADDR, S_CMD, S_WDATA: begin
               if (scl_rise) begin
                  d.shreg = {q.shreg[6:0], sda};
                  d.cnt   = q.cnt + 3'h1;
                  d.full  = (q.cnt == BIT_LAST);
               end
               if (scl_fall && q.full) begin
                  d.full = 1'b0;
                  d.cnt  = 3'h0;
                  case (q.state)
                     S_ADDR: begin
                        if (q.shreg[7:1] == dev_addr) begin
                           d.rw        = q.shreg[0];
                           d.drv       = 1'b1;
                           d.addressed = 1'b1;
                           d.state     = S_AACK;
                        end else begin
                           // other slaves' traffic is ignored entirely
                           d.state = S_SKIP;
                        end
                     end
                     S_CMD: begin
                        d.regs.ptr = q.shreg;
                        d.drv      = 1'b1;
                        d.state    = S_CACK;
                     end
                     default: begin
                        // same register every byte, last one wins
                        case (q.regs.ptr[1:0])
                           PTR_LATCH:  d.regs.latch  = q.shreg;
                           PTR_INVERT: d.regs.invert = q.shreg;
                           PTR_DIR:    d.regs.dir    = q.shreg;
                           default:    d.regs.latch  = q.regs.latch;
                        endcase
                        d.drv   = 1'b1;
                        d.state = S_WACK;
                     end
                  endcase
               end
            end
            S_AACK, S_CACK, S_WACK: begin
               if (scl_rise && q.state == S_AACK && q.rw
                   && q.regs.ptr[1:0] == PTR_INPUT) begin
                  d.regs.inport = q.pin_s1;
               end
               if (scl_fall) begin
                  d.drv = 1'b0;
                  d.cnt = 3'h0;
                  if (q.state == S_AACK && q.rw) begin
                     // no command byte in a read, the pointer is reused
                     d.shreg = rd_byte;
                     d.drv   = ~rd_byte[7];
                     d.state = S_RDATA;
                  end else if (q.state == S_AACK) begin
                     d.state = S_CMD;
                  end else begin
                     d.state = S_WDATA;
                  end
               end
            end
            S_RDATA: begin
               if (scl_fall) begin
                  if (q.cnt == BIT_LAST) begin
                     d.drv   = 1'b0;
                     d.cnt   = 3'h0;
                     d.state = S_MACK;
                  end else begin
                     d.shreg = {q.shreg[6:0], 1'b0};
                     d.drv   = ~q.shreg[6];
                     d.cnt   = q.cnt + 3'h1;
                  end
               end
            end
            S_MACK: begin
               if (scl_rise) begin
                  d.nacked = sda;
                  if (q.regs.ptr[1:0] == PTR_INPUT) begin
                     d.regs.inport = q.pin_s1;
                  end
               end
               if (scl_fall) begin
                  if (q.nacked) begin
                     d.state = S_SKIP;
                  end else begin
                     d.shreg = rd_byte;
                     d.drv   = ~rd_byte[7];
                     d.state = S_RDATA;
                  end
               end
            end
            S_IDLE, S_SKIP: begin
               d.drv = 1'b0;
            end
            default: begin
               d.state = S_IDLE;
               d.drv   = 1'b0;
            end
         endcase
      end
   end

   // reset pin holds every register at its default while low
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         q <= ST_RST;
      end else if (ce_i) begin
         q <= d;
      end
   end

   assign sda_o            = 1'b0;
   assign sda_oe_n_o       = ~q.drv;
   assign port_drv_o       = '{level: q.regs.latch, oe_n: q.regs.dir};
   assign irq_n_o          = 1'b0;
   assign irq_oe_n_o       = ~q.irq;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n || !ce_i);

   sequence s_addr_done;
      q.state == S_ADDR && scl_fall && q.full;
   endsequence

   sequence s_data_done;
      q.state == S_WDATA && scl_fall && q.full;
   endsequence

   sequence s_read_ack_rise;
      (q.state == S_MACK || (q.state == S_AACK && q.rw)) && scl_rise
         && q.regs.ptr[1:0] == PTR_INPUT;
   endsequence

   AST_ADDR_ACK: assert property (
      s_addr_done ##0 (q.shreg[7:1] == dev_addr)
         |=> q.state == S_AACK && !sda_oe_n_o && q.addressed)
      else $error("own address not acknowledged");

   AST_ADDR_OTHER: assert property (
      s_addr_done ##0 (q.shreg[7:1] != dev_addr)
         |=> q.state == S_SKIP && sda_oe_n_o && $stable(q.regs.inport))
      else $error("foreign address disturbed the slave");

   AST_CMD_STORE: assert property (
      (q.state == S_CMD && scl_fall && q.full)
         |=> q.regs.ptr == $past(q.shreg) && q.state == S_CACK)
      else $error("command byte not stored in pointer");

   AST_PTR_HOLD: assert property (
      $changed(q.regs.ptr) |-> $past(q.state) == S_CMD)
      else $error("pointer changed outside a command byte");

   AST_INPUT_RO: assert property (
      s_data_done ##0 (q.regs.ptr[1:0] == PTR_INPUT)
         |=> $stable(q.regs.latch) && $stable(q.regs.invert) && $stable(q.regs.dir))
      else $error("write to input register changed state");

   AST_LATCH_WRITE: assert property (
      s_data_done ##0 (q.regs.ptr[1:0] == PTR_LATCH)
         |=> port_drv_o.level == $past(q.shreg) ##1 !sda_oe_n_o)
      else $error("latch write not on pins at its ack");

   AST_READ_CLEAR: assert property (
      s_read_ack_rise |=> q.regs.inport == $past(q.pin_s1))
      else $error("input snapshot not taken at ack rising edge");

   AST_STOP_CLEAR: assert property (
      (stop_c && q.addressed)
         |=> q.state == S_IDLE && sda_oe_n_o && q.regs.inport == $past(q.pin_s1))
      else $error("stop did not clear interrupt state");

   AST_IRQ_SET: assert property (
      (|mismatch) |=> !irq_oe_n_o)
      else $error("input change did not assert interrupt");

   AST_IRQ_CAUSE: assert property (
      !irq_oe_n_o |-> $past(|mismatch))
      else $error("interrupt without an input pin change");

   AST_NACK_END: assert property (
      (q.state == S_MACK && q.nacked && scl_fall) |=> q.state == S_SKIP && sda_oe_n_o)
      else $error("slave kept sending after nack");

   AST_RESET_DEFAULTS: assert property (
      (q.prime == 2'h0)
         |-> q.regs.latch == RST_LATCH && q.regs.invert == RST_INVERT
            && q.regs.dir == RST_DIR && q.state == S_IDLE)
      else $error("registers not at defaults after reset");

endmodule
`default_nettype wire

// File: bench/i2cgx_master_model.sv
// behavioural i2c bus master: drives scl and its side of sda
`default_nettype none
module i2cgx_master_model (
   // clock
   input  wire logic clk_i,
   // bus lines
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic w(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   // 5 cycles low, 3 high: sda only moves while scl is low
   task automatic bit_cyc(input logic b, output logic s);
      w(2);
      sda_o = b;
      w(3);
      scl_o = 1'b1;
      w(2);
      s = sda_i;
      w(1);
      scl_o = 1'b0;
   endtask

   // long low phase first so a slave ack is gone before scl rises
   task automatic start;
      sda_o = 1'b1;
      w(5);
      scl_o = 1'b1;
      w(3);
      sda_o = 1'b0;
      w(3);
      scl_o = 1'b0;
   endtask

   task automatic stop;
      w(2);
      sda_o = 1'b0;
      w(3);
      scl_o = 1'b1;
      w(3);
      sda_o = 1'b1;
      w(3);
   endtask

   // eight bits msb first then the ack bit; reads send 0xff to release sda
   task automatic xfer(input logic [7:0] tx, input logic ab, output logic [7:0] rx,
                       output logic as);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(tx[i], s);
         rx[i] = s;
      end
      bit_cyc(ab, as);
   endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
// self-checking bench for the i2c port expander core
`default_nettype none
module tb
   import i2cgx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic       clk;
   logic       rst_n = 1'b0;
   logic       scl;
   logic       sda_m;
   logic       sda_oe_n;
   logic       sda_v;
   logic       irq_oe_n;
   logic       irq_v;
   logic [2:0] sel = 3'h5;
   logic [7:0] ext = 8'h00;
   logic [7:0] rv;
   logic       ak;
   i2cgx_drv_t drv;
   int         bad_count = 0;
   int         cmp_count = 0;
   logic [7:0] rst_v [3] = '{RST_LATCH, RST_INVERT, RST_DIR};
   logic [7:0] wv [3]    = '{8'ha5, 8'h3c, 8'h0f};
   // pull-ups on sda; driven pins follow the latch, others the board
   wire logic       sda  = sda_m & (sda_oe_n | sda_v);
   wire logic       irq  = irq_oe_n | irq_v;
   wire logic [7:0] pins = (~drv.oe_n & drv.level) | (drv.oe_n & ext);

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   i2cgx_core i_i2cgx_core (
      .clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_v), .sda_oe_n_o(sda_oe_n), .addr_select_pins_i(sel), .port_pins_i(pins),
      .port_drv_o(drv), .irq_n_o(irq_v), .irq_oe_n_o(irq_oe_n));

   i2cgx_master_model i_i2cgx_master_model (
      .clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));

   task automatic w(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic head(input logic [2:0] a, input logic rw);
      i_i2cgx_master_model.start();
      i_i2cgx_master_model.xfer({ADDR_FIXED, a, rw}, 1'b1, rv, ak);
   endtask

   task automatic wr(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1,
                     input int n);
      head(sel, 1'b0);
      chk("addr ack", ak, 1'b0);
      i_i2cgx_master_model.xfer(p, 1'b1, rv, ak);
      chk("cmd ack", ak, 1'b0);
      for (int i = 0; i < n; i++) begin
         i_i2cgx_master_model.xfer(i ? d1 : d0, 1'b1, rv, ak);
         chk("data ack", ak, 1'b0);
         if (p[1:0] == PTR_LATCH) chk("pin level", drv.level, i ? d1 : d0);
      end
      i_i2cgx_master_model.stop();
   endtask

   // cmd low reuses the stored pointer
   task automatic rd(input logic [7:0] p, input logic cmd, output logic [7:0] d);
      if (cmd) begin
         head(sel, 1'b0);
         i_i2cgx_master_model.xfer(p, 1'b1, rv, ak);
      end
      head(sel, 1'b1);
      chk("read ack", ak, 1'b0);
      i_i2cgx_master_model.xfer(8'hff, 1'b1, d, ak);
      i_i2cgx_master_model.stop();
   endtask

   task automatic irq_is(input logic e);
      w(6);
      chk("irq", irq, e);
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      w(60000);
      bad_count++;
      wrap_up();
   end

   initial begin
      w(5);
      rst_n = 1'b1;
      w(10);
      chk("level", drv.level, RST_LATCH);
      chk("oe_n", drv.oe_n, RST_DIR);
      chk("irq", irq, 1'b1);
      for (int i = 0; i < 3; i++) begin
         rd(8'(i + 1), 1'b1, rv);
         chk("reg reset", rv, rst_v[i]);
      end
      for (int i = 0; i < 3; i++) begin
         wr(8'(i + 1), wv[i], 8'h00, 1);
         rd(8'(i + 1), 1'b1, rv);
         chk("reg rw", rv, wv[i]);
      end
      chk("oe_n", drv.oe_n, 8'h0f);
      chk("level", drv.level, 8'ha5);
      rd(8'h01, 1'b1, rv);
      chk("latch", rv, 8'ha5);
      rd(8'h00, 1'b0, rv);
      chk("latch again", rv, 8'ha5);
      ext = 8'h66;
      wr(8'h00, 8'h55, 8'h00, 1);
      rd(8'h00, 1'b1, rv);
      // pins: latch on bits 7..4, board on 3..0; inversion only on inputs
      chk("input", rv, 8'ha6 ^ (8'h3c & 8'h0f));
      wr(8'h02, 8'h11, 8'h22, 2);
      rd(8'h02, 1'b1, rv);
      chk("last byte", rv, 8'h22);
      wr(8'h01, 8'h5a, 8'hc3, 2);
      head(sel, 1'b0);
      i_i2cgx_master_model.xfer(8'h01, 1'b1, rv, ak);
      for (int i = 0; i < 4; i++) i_i2cgx_master_model.bit_cyc(1'b0, ak);
      i_i2cgx_master_model.stop();
      rd(8'h01, 1'b1, rv);
      chk("latch abort", rv, 8'hc3);
      chk("level abort", drv.level, 8'hc3);
      head(3'h2, 1'b0);
      chk("foreign ack", ak, 1'b1);
      i_i2cgx_master_model.stop();
      wr(8'h03, 8'hff, 8'h00, 1);
      rd(8'h00, 1'b1, rv);
      ext = 8'h67;
      irq_is(1'b0);
      ext = 8'h66;
      irq_is(1'b1);
      ext = 8'h64;
      irq_is(1'b0);
      head(3'h2, 1'b0);
      i_i2cgx_master_model.xfer(8'h00, 1'b1, rv, ak);
      i_i2cgx_master_model.stop();
      irq_is(1'b0);
      rd(8'h00, 1'b1, rv);
      chk("input", rv, 8'h64 ^ 8'h22);
      irq_is(1'b1);
      ext = 8'h66;
      irq_is(1'b0);
      wr(8'h01, 8'h00, 8'h00, 1);
      irq_is(1'b1);
      wr(8'h03, 8'h00, 8'h00, 1);
      ext = 8'h99;
      irq_is(1'b1);
      rst_n = 1'b0;
      w(3);
      chk("oe_n hold", drv.oe_n, RST_DIR);
      chk("sda hold", sda_oe_n, 1'b1);
      rst_n = 1'b1;
      w(10);
      chk("irq after reset", irq, 1'b1);
      rd(8'h02, 1'b1, rv);
      chk("invert", rv, RST_INVERT);
      wrap_up();
   end
endmodule
`default_nettype wire
